// >>> hdl/dpc_cfg.svh
// Offsets, field positions, reset values and timing constants of the debug-port control block.
`ifndef DPC_CFG_SVH
`define DPC_CFG_SVH

// ****************************************************************
// Register map on the debug link
// ****************************************************************
`define DPC_CTRL_ADDR      8'h03
`define DPC_SFR_BASE       8'h80
`define DPC_CTRL_RESET     8'h00

// ****************************************************************
// Control register field positions
// ****************************************************************
`define DPC_BIT_WR_EN      0
`define DPC_BIT_RD_EN      1
`define DPC_BIT_IMMED      2
`define DPC_BIT_SUPPRESS   3
`define DPC_BIT_BLOCK      4
`define DPC_BIT_ACTIVE     5
`define DPC_SPARE_VALUE    2'h0

// ****************************************************************
// Timing
// ****************************************************************
`define DPC_PULSE_NS       1000
`define DPC_CLK_NS         100
`define DPC_PULSE_CYCLES   ((`DPC_PULSE_NS + `DPC_CLK_NS - 1) / `DPC_CLK_NS)

`endif

// >>> hdl/dpc_pkg.sv
// Types shared by the debug-port control block.
package dpc_pkg;

    // States of the system-side quick access engine.
    typedef enum logic [0:0] {
        DPC_FP_IDLE,
        DPC_FP_WAIT
    } dpc_fp_state_t;

    // States of the halt pulse generator.
    typedef enum logic [0:0] {
        DPC_PULSE_IDLE,
        DPC_PULSE_LOW
    } dpc_pulse_state_t;

endpackage : dpc_pkg

// >>> hdl/dpc_sync.sv
// Two-flop level synchroniser of parameterised width.
`timescale 1ns/1ps

module dpc_sync #(
    parameter int WIDTH = 1
) (
    input  wire logic             clk,
    input  wire logic [WIDTH-1:0] asyncIn,
    output logic      [WIDTH-1:0] syncOut
);

    logic [WIDTH-1:0] stageOne;
    logic [WIDTH-1:0] next_stageOne;
    logic [WIDTH-1:0] next_syncOut;

    // The first stage feeds only the second stage.
    always_comb begin
        next_stageOne = asyncIn;
        next_syncOut  = stageOne;
    end

    // Both stages register on every rising edge.
    always_ff @(posedge clk) begin
        stageOne <= next_stageOne;
        syncOut  <= next_syncOut;
    end

endmodule : dpc_sync

// >>> hdl/dpc_debug_port_ctrl.sv
// Debug-port control register with quick SFR access, halt control and pin sharing.
`timescale 1ns/1ps
`include "dpc_cfg.svh"

module dpc_debug_port_ctrl #(
    parameter int ADDR_W    = 8,
    parameter int DATA_W    = 8,
    parameter int PULSE_W   = 4
) (
    input  wire logic              ref_clk,
    input  wire logic              reset_n,
    input  wire logic              linkClk,
    input  wire logic              linkRegWrite,
    input  wire logic              linkRegRead,
    input  wire logic [ADDR_W-1:0] linkRegAddr,
    input  wire logic [DATA_W-1:0] linkRegWdata,
    output logic      [DATA_W-1:0] linkRegRdata,
    output logic                   linkQuickBusy,
    output logic                   sfrReq,
    output logic                   sfrWrite,
    output logic      [ADDR_W-1:0] sfrAddr,
    output logic      [DATA_W-1:0] sfrWdata,
    input  wire logic              sfrDone,
    input  wire logic [DATA_W-1:0] sfrRdata,
    input  wire logic              coreHaltRequest,
    input  wire logic              cpuBoundary,
    output logic                   coreHaltStop,
    input  wire logic              debugBreakInterrupt,
    output logic                   haltPulseAck,
    output logic                   debugClockPinOut,
    output logic                   debugClockPinOe,
    input  wire logic              ledRequest,
    input  wire logic              linkEnable,
    output logic                   ledDriveEnable,
    output logic                   linkFsmHoldReset
);

    localparam logic [PULSE_W-1:0] PULSE_LAST = PULSE_W'(`DPC_PULSE_CYCLES - 1);

    // ****************************************************************
    // Link clock domain
    // ****************************************************************
    logic              linkReset_n;
    logic [DATA_W-1:0] ctrl;
    logic [DATA_W-1:0] next_ctrl;
    logic              reqTog;
    logic              next_reqTog;
    logic              reqWrite;
    logic              next_reqWrite;
    logic [ADDR_W-1:0] reqAddr;
    logic [ADDR_W-1:0] next_reqAddr;
    logic [DATA_W-1:0] reqWdata;
    logic [DATA_W-1:0] next_reqWdata;
    logic              ackSeen;
    logic              next_ackSeen;
    logic              ackSync;
    logic [DATA_W-1:0] next_linkRegRdata;
    logic              next_linkQuickBusy;
    logic              busy;
    logic              sfrSpace;
    logic              ackTog;
    logic [DATA_W-1:0] sysRdata;

    // Reset release is brought into the link domain before use.
    dpc_sync #(.WIDTH(1)) uLinkRst (
        .clk     (linkClk),
        .asyncIn (reset_n),
        .syncOut (linkReset_n)
    );

    // Answer toggle from the system domain.
    dpc_sync #(.WIDTH(1)) uAckSync (
        .clk     (linkClk),
        .asyncIn (ackTog),
        .syncOut (ackSync)
    );

    // Control register, request launch and read data selection.
    always_comb begin
        busy              = reqTog ^ ackSeen;
        sfrSpace          = linkRegAddr >= `DPC_SFR_BASE;
        next_ctrl         = ctrl;
        next_reqTog       = reqTog;
        next_reqWrite     = reqWrite;
        next_reqAddr      = reqAddr;
        next_reqWdata     = reqWdata;
        next_ackSeen      = ackSync;
        next_linkRegRdata = linkRegRdata;
        if (linkRegWrite && linkRegAddr == `DPC_CTRL_ADDR) begin
            next_ctrl = {3'h0, linkRegWdata[`DPC_BIT_BLOCK:0]};
        end
        if (!busy && sfrSpace) begin
            if (linkRegWrite && ctrl[`DPC_BIT_WR_EN]) begin
                next_reqTog   = ~reqTog;
                next_reqWrite = 1'b1;
                next_reqAddr  = linkRegAddr;
                next_reqWdata = linkRegWdata;
            end else if (linkRegRead && ctrl[`DPC_BIT_RD_EN]) begin
                next_reqTog   = ~reqTog;
                next_reqWrite = 1'b0;
                next_reqAddr  = linkRegAddr;
            end
        end
        if (linkRegRead && linkRegAddr == `DPC_CTRL_ADDR) begin
            next_linkRegRdata = ctrl;
            next_linkRegRdata[`DPC_BIT_ACTIVE] = busy;
            next_linkRegRdata[DATA_W-1:DATA_W-2] = `DPC_SPARE_VALUE;
        end else if (ackSync != ackSeen && !reqWrite) begin
            next_linkRegRdata = sysRdata;
        end
        next_linkQuickBusy = (next_reqTog ^ next_ackSeen);
    end

    // Link domain registers.
    always_ff @(posedge linkClk) begin
        if (!linkReset_n) begin
            ctrl          <= `DPC_CTRL_RESET;
            reqTog        <= 1'b0;
            reqWrite      <= 1'b0;
            reqAddr       <= '0;
            reqWdata      <= '0;
            ackSeen       <= 1'b0;
            linkRegRdata  <= '0;
            linkQuickBusy <= 1'b0;
        end else begin
            ctrl          <= next_ctrl;
            reqTog        <= next_reqTog;
            reqWrite      <= next_reqWrite;
            reqAddr       <= next_reqAddr;
            reqWdata      <= next_reqWdata;
            ackSeen       <= next_ackSeen;
            linkRegRdata  <= next_linkRegRdata;
            linkQuickBusy <= next_linkQuickBusy;
        end
    end

    // ****************************************************************
    // System clock domain
    // ****************************************************************
    logic [2:0]                   ctrlSync;
    logic                         reqSync;
    logic                         reqSeen;
    logic                         next_reqSeen;
    logic                         next_ackTog;
    logic [DATA_W-1:0]            next_sysRdata;
    dpc_pkg::dpc_fp_state_t       fpState;
    dpc_pkg::dpc_fp_state_t       next_fpState;
    logic                         next_sfrReq;
    logic                         next_sfrWrite;
    logic [ADDR_W-1:0]            next_sfrAddr;
    logic [DATA_W-1:0]            next_sfrWdata;
    dpc_pkg::dpc_pulse_state_t    pulseState;
    dpc_pkg::dpc_pulse_state_t    next_pulseState;
    logic [PULSE_W-1:0]           pulseCnt;
    logic [PULSE_W-1:0]           next_pulseCnt;
    logic                         next_haltPulseAck;
    logic                         next_debugClockPinOut;
    logic                         next_debugClockPinOe;
    logic                         next_coreHaltStop;
    logic                         next_ledDriveEnable;
    logic                         next_linkFsmHoldReset;
    logic                         immedSel;
    logic                         suppress;
    logic                         block;

    // Control bits that steer system logic.
    dpc_sync #(.WIDTH(3)) uCtrlSync (
        .clk     (ref_clk),
        .asyncIn (ctrl[`DPC_BIT_BLOCK:`DPC_BIT_IMMED]),
        .syncOut (ctrlSync)
    );

    // Request toggle from the link domain.
    dpc_sync #(.WIDTH(1)) uReqSync (
        .clk     (ref_clk),
        .asyncIn (reqTog),
        .syncOut (reqSync)
    );

    // Quick access engine: one SFR access per request toggle.
    always_comb begin
        next_fpState  = fpState;
        next_reqSeen  = reqSeen;
        next_ackTog   = ackTog;
        next_sysRdata = sysRdata;
        next_sfrReq   = 1'b0;
        next_sfrWrite = sfrWrite;
        next_sfrAddr  = sfrAddr;
        next_sfrWdata = sfrWdata;
        case (fpState)
            dpc_pkg::DPC_FP_IDLE: begin
                if (reqSync != reqSeen) begin
                    next_reqSeen  = reqSync;
                    next_sfrReq   = 1'b1;
                    next_sfrWrite = reqWrite;
                    next_sfrAddr  = reqAddr;
                    next_sfrWdata = reqWdata;
                    next_fpState  = dpc_pkg::DPC_FP_WAIT;
                end
            end
            dpc_pkg::DPC_FP_WAIT: begin
                if (sfrDone) begin
                    next_sysRdata = sfrRdata;
                    next_ackTog   = ~ackTog;
                    next_fpState  = dpc_pkg::DPC_FP_IDLE;
                end
            end
            default: begin
                next_fpState = dpc_pkg::DPC_FP_IDLE;
            end
        endcase
    end

    // Halt pulse, core halt and shared pin control.
    always_comb begin
        immedSel              = ctrlSync[0];
        suppress              = ctrlSync[1];
        block                 = ctrlSync[2];
        next_pulseState       = pulseState;
        next_pulseCnt         = pulseCnt;
        next_haltPulseAck     = 1'b0;
        next_debugClockPinOut = 1'b0;
        next_debugClockPinOe  = 1'b0;
        case (pulseState)
            dpc_pkg::DPC_PULSE_IDLE: begin
                if (debugBreakInterrupt && suppress) begin
                    next_haltPulseAck = 1'b1;
                end else if (debugBreakInterrupt) begin
                    next_pulseState      = dpc_pkg::DPC_PULSE_LOW;
                    next_pulseCnt        = '0;
                    next_debugClockPinOe = 1'b1;
                end
            end
            dpc_pkg::DPC_PULSE_LOW: begin
                next_debugClockPinOe = 1'b1;
                next_pulseCnt        = pulseCnt + PULSE_W'(1);
                if (pulseCnt == PULSE_LAST) begin
                    next_debugClockPinOe = 1'b0;
                    next_haltPulseAck    = 1'b1;
                    next_pulseState      = dpc_pkg::DPC_PULSE_IDLE;
                end
            end
            default: begin
                next_pulseState = dpc_pkg::DPC_PULSE_IDLE;
            end
        endcase
        next_coreHaltStop     = coreHaltRequest && (immedSel || cpuBoundary || coreHaltStop);
        next_ledDriveEnable   = ledRequest && !block && !next_debugClockPinOe;
        next_linkFsmHoldReset = next_ledDriveEnable || !linkEnable;
    end

    // System domain registers.
    always_ff @(posedge ref_clk) begin
        if (!reset_n) begin
            fpState          <= dpc_pkg::DPC_FP_IDLE;
            reqSeen          <= 1'b0;
            ackTog           <= 1'b0;
            sysRdata         <= '0;
            sfrReq           <= 1'b0;
            sfrWrite         <= 1'b0;
            sfrAddr          <= '0;
            sfrWdata         <= '0;
            pulseState       <= dpc_pkg::DPC_PULSE_IDLE;
            pulseCnt         <= '0;
            haltPulseAck     <= 1'b0;
            debugClockPinOut <= 1'b0;
            debugClockPinOe  <= 1'b0;
            coreHaltStop     <= 1'b0;
            ledDriveEnable   <= 1'b0;
            linkFsmHoldReset <= 1'b1;
        end else begin
            fpState          <= next_fpState;
            reqSeen          <= next_reqSeen;
            ackTog           <= next_ackTog;
            sysRdata         <= next_sysRdata;
            sfrReq           <= next_sfrReq;
            sfrWrite         <= next_sfrWrite;
            sfrAddr          <= next_sfrAddr;
            sfrWdata         <= next_sfrWdata;
            pulseState       <= next_pulseState;
            pulseCnt         <= next_pulseCnt;
            haltPulseAck     <= next_haltPulseAck;
            debugClockPinOut <= next_debugClockPinOut;
            debugClockPinOe  <= next_debugClockPinOe;
            coreHaltStop     <= next_coreHaltStop;
            ledDriveEnable   <= next_ledDriveEnable;
            linkFsmHoldReset <= next_linkFsmHoldReset;
        end
    end

endmodule : dpc_debug_port_ctrl

// >>> bench/dpc_ctrl_assertions.sv
// Concurrent checks on the ports of the debug-port control block.
`timescale 1ns/1ps

module dpc_ctrl_assertions (
    input wire logic ref_clk,
    input wire logic reset_n,
    input wire logic linkClk,
    input wire logic linkQuickBusy,
    input wire logic sfrReq,
    input wire logic coreHaltRequest,
    input wire logic coreHaltStop,
    input wire logic haltPulseAck,
    input wire logic debugClockPinOut,
    input wire logic debugClockPinOe,
    input wire logic ledRequest,
    input wire logic linkEnable,
    input wire logic ledDriveEnable,
    input wire logic linkFsmHoldReset
);
    // ****************************************************************
    // Halt pulse on the shared clock pin
    // ****************************************************************
    a_pin_low: assert property (@(posedge ref_clk) disable iff (!reset_n)
        debugClockPinOe |-> !debugClockPinOut) else $error("Halt pin driven high.");
    a_pulse_long: assert property (@(posedge ref_clk) disable iff (!reset_n)
        $rose(debugClockPinOe) |-> debugClockPinOe[*8] ##1 debugClockPinOe[*2])
        else $error("Halt pulse too short.");
    a_ack_after_pulse: assert property (@(posedge ref_clk) disable iff (!reset_n)
        $fell(debugClockPinOe) |-> ##[0:1] haltPulseAck) else $error("No ack after pulse.");
    a_ack_pin_idle: assert property (@(posedge ref_clk) disable iff (!reset_n)
        haltPulseAck |-> !debugClockPinOe) else $error("Ack while pin driven.");
    // ****************************************************************
    // Pin sharing, link hold, core halt and quick access
    // ****************************************************************
    a_led_off_pulse: assert property (@(posedge ref_clk) disable iff (!reset_n)
        debugClockPinOe && $past(debugClockPinOe) |-> !ledDriveEnable)
        else $error("Indicator drives during pulse.");
    a_led_no_req: assert property (@(posedge ref_clk) disable iff (!reset_n)
        !ledRequest |=> !ledDriveEnable) else $error("Indicator drives without request.");
    a_hold_on_led: assert property (@(posedge ref_clk) disable iff (!reset_n)
        ledDriveEnable |-> linkFsmHoldReset) else $error("Link not held while indicator on.");
    a_hold_link_off: assert property (@(posedge ref_clk) disable iff (!reset_n)
        !linkEnable |=> linkFsmHoldReset) else $error("Link not held while disabled.");
    a_halt_release: assert property (@(posedge ref_clk) disable iff (!reset_n)
        !coreHaltRequest |=> !coreHaltStop) else $error("Halt kept without request.");
    a_sfr_single: assert property (@(posedge ref_clk) disable iff (!reset_n)
        sfrReq |=> !sfrReq) else $error("SFR request longer than one cycle.");
    a_busy_span: assert property (@(posedge linkClk) disable iff (!reset_n)
        $rose(linkQuickBusy) |-> linkQuickBusy[*2]) else $error("Busy dropped too soon.");
endmodule : dpc_ctrl_assertions

bind dpc_debug_port_ctrl dpc_ctrl_assertions chk_u (.*);

// >>> bench/dpc_core_model.sv
// Behavioural core that answers SFR accesses after a set delay.
`timescale 1ns/1ps

module dpc_core_model (
    input  wire logic       ref_clk,
    input  wire logic       reset_n,
    input  wire logic       sfrReq,
    input  wire logic       sfrWrite,
    input  wire logic [7:0] sfrAddr,
    input  wire logic [7:0] sfrWdata,
    input  wire logic [7:0] respDelay,
    output logic            sfrDone,
    output logic      [7:0] sfrRdata,
    output logic      [7:0] lastAddr,
    output logic      [7:0] lastWdata,
    output logic            lastWrite,
    output logic      [7:0] reqCount
);
    logic       pend;
    logic [7:0] cnt;

    // Captures a request, waits the chosen delay, then gives one done pulse.
    always_ff @(posedge ref_clk) begin
        sfrDone <= 1'b0;
        if (!reset_n) begin
            pend     <= 1'b0;
            reqCount <= 8'h00;
        end else if (sfrReq) begin
            pend      <= 1'b1;
            cnt       <= respDelay;
            lastAddr  <= sfrAddr;
            lastWdata <= sfrWdata;
            lastWrite <= sfrWrite;
            reqCount  <= reqCount + 8'h01;
        end else if (pend && cnt == 8'h00) begin
            pend    <= 1'b0;
            sfrDone <= 1'b1;
        end else if (pend) begin
            cnt <= cnt - 8'h01;
        end
    end

    // Read data is valid only with done; otherwise the inverse shows.
    assign sfrRdata = sfrDone ? (lastAddr ^ 8'h5A) : ~(lastAddr ^ 8'h5A);
endmodule : dpc_core_model

// >>> bench/dpc_debug_port_ctrl_tb_top.sv
// Self-checking testbench of the debug-port control block.
`timescale 1ns/1ps

module dpc_debug_port_ctrl_tb_top;
    logic       ref_clk = 1'b0, reset_n = 1'b0, linkClk = 1'b0, linkRun = 1'b1;
    logic       linkRegWrite = 1'b0, linkRegRead = 1'b0, linkQuickBusy, sfrReq, sfrWrite, sfrDone;
    logic [7:0] linkRegAddr = 8'h00, linkRegWdata = 8'h00, linkRegRdata, sfrAddr, sfrWdata;
    logic       coreHaltRequest = 1'b0, cpuBoundary = 1'b0, debugBreakInterrupt = 1'b0;
    logic       haltPulseAck, debugClockPinOut, debugClockPinOe, ledRequest = 1'b0, coreHaltStop;
    logic       linkEnable = 1'b1, ledDriveEnable, linkFsmHoldReset, lastWrite;
    logic [7:0] lastAddr, lastWdata, reqCount, respDelay = 8'h03, lowCnt, ackCnt, sfrRdata;
    int         err_total = 0, n_compared = 0;

    // Clocks: the link clock stands still while the master stretches it.
    always #50 ref_clk = ~ref_clk;
    always #32 linkClk = linkRun ? ~linkClk : 1'b0;

    dpc_debug_port_ctrl dut_u (.*);
    dpc_core_model core_u (.*);

    // ****************************************************************
    // Tasks
    // ****************************************************************
    task chk(input logic [7:0] got, input logic [7:0] exp, input string what);
        n_compared++;
        if (got !== exp) begin
            err_total++;
            $display("Error at %0t: %s got %h expected %h", $time, what, got, exp);
        end
    endtask : chk

    task end_sim;
        $display("Mismatches %0d, comparisons %0d", err_total, n_compared);
        if (err_total == 0 && n_compared > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask : end_sim

    task lw(input logic [7:0] a, input logic [7:0] d);
        @(posedge linkClk);
        linkRegWrite <= 1'b1;
        linkRegAddr  <= a;
        linkRegWdata <= d;
        @(posedge linkClk);
        linkRegWrite <= 1'b0;
        // Step off the edge so that callers see the registered response.
        #1;
    endtask : lw

    task lr(input logic [7:0] a);
        @(posedge linkClk);
        linkRegRead <= 1'b1;
        linkRegAddr <= a;
        @(posedge linkClk);
        linkRegRead <= 1'b0;
        #1;
    endtask : lr

    task cyc(input int n);
        repeat (n) @(posedge ref_clk);
        #1;
    endtask : cyc

    // Writes the control register and lets the bits reach the system side.
    task setc(input logic [7:0] d);
        lw(8'h03, d);
        cyc(6);
    endtask : setc

    // Waits for the quick access answer, bounded.
    task waitq;
        for (int i = 0; i < 40 && linkQuickBusy !== 1'b0; i++) @(posedge linkClk) #1;
        chk({7'h00, linkQuickBusy}, 8'h00, "quick busy");
    endtask : waitq

    // Raises a breakpoint and counts pin-low cycles and acks.
    task brk(input logic [7:0] expLow);
        @(posedge ref_clk) debugBreakInterrupt <= 1'b1;
        @(posedge ref_clk) debugBreakInterrupt <= 1'b0;
        lowCnt = 8'h00;
        ackCnt = 8'h00;
        repeat (20) begin
            #1;
            lowCnt += {7'h00, debugClockPinOe};
            ackCnt += {7'h00, haltPulseAck};
            @(posedge ref_clk);
        end
        chk(lowCnt, expLow, "pin low cycles");
        chk(ackCnt, 8'h01, "service ack");
    endtask : brk

    // Cuts a hung run short.
    initial begin
        #2000000;
        err_total++;
        $display("Error at %0t: watchdog expired", $time);
        end_sim();
    end

    // ****************************************************************
    // Main sequence
    // ****************************************************************
    initial begin
        repeat (8) @(posedge ref_clk);
        reset_n <= 1'b1;
        repeat (3) @(posedge linkClk);
        lr(8'h03);
        chk(linkRegRdata, 8'h00, "reset value");
        lw(8'h03, 8'hFF);
        lr(8'h03);
        chk(linkRegRdata, 8'h1F, "spare bits");
        lw(8'h03, 8'h00);
        lr(8'h03);
        chk(linkRegRdata, 8'h00, "clear by write");
        lw(8'h10, 8'hFF);
        lr(8'h03);
        chk(linkRegRdata, 8'h00, "unmapped write");
        lr(8'h90);
        cyc(10);
        chk(reqCount, 8'h00, "read while disabled");
        setc(8'h02);
        lr(8'h90);
        lr(8'h03);
        chk(linkRegRdata, 8'h22, "busy bit");
        // The master holds the link clock for 700 ns, about eleven link clock periods, for the quick read.
        linkRun = 1'b0;
        #700 linkRun = 1'b1;
        waitq();
        chk(linkRegRdata, 8'h90 ^ 8'h5A, "quick read data");
        chk(lastAddr, 8'h90, "sfr address");
        chk({7'h00, lastWrite}, 8'h00, "sfr read kind");
        lr(8'h03);
        chk(linkRegRdata, 8'h02, "idle bit");
        setc(8'h01);
        respDelay <= 8'h0C;
        lw(8'h85, 8'h3C);
        waitq();
        chk(lastWdata, 8'h3C, "quick write data");
        chk(lastAddr, 8'h85, "sfr write address");
        chk({7'h00, lastWrite}, 8'h01, "sfr write kind");
        setc(8'h00);
        brk(8'h0A);
        setc(8'h08);
        brk(8'h00);
        // With the pulse suppressed the master learns the state by polling.
        lr(8'h03);
        chk(linkRegRdata, 8'h08, "polled state");
        setc(8'h00);
        @(posedge ref_clk) coreHaltRequest <= 1'b1;
        cyc(4);
        chk({7'h00, coreHaltStop}, 8'h00, "wait for boundary");
        @(posedge ref_clk) cpuBoundary <= 1'b1;
        cyc(2);
        chk({7'h00, coreHaltStop}, 8'h01, "synchronous halt");
        @(posedge ref_clk) coreHaltRequest <= 1'b0;
        cpuBoundary <= 1'b0;
        setc(8'h04);
        @(posedge ref_clk) coreHaltRequest <= 1'b1;
        cyc(2);
        chk({7'h00, coreHaltStop}, 8'h01, "immediate halt");
        @(posedge ref_clk) coreHaltRequest <= 1'b0;
        setc(8'h00);
        @(posedge ref_clk) ledRequest <= 1'b1;
        cyc(2);
        chk({6'h00, ledDriveEnable, linkFsmHoldReset}, 8'h03, "indicator on");
        setc(8'h10);
        chk({6'h00, ledDriveEnable, linkFsmHoldReset}, 8'h00, "blocked");
        @(posedge ref_clk) linkEnable <= 1'b0;
        cyc(2);
        chk({7'h00, linkFsmHoldReset}, 8'h01, "link disabled");
        @(posedge ref_clk) linkEnable <= 1'b1;
        brk(8'h0A);
        lr(8'h03);
        chk(linkRegRdata, 8'h10, "block kept");
        setc(8'h00);
        chk({7'h00, ledDriveEnable}, 8'h01, "unblocked");
        // A power-on reset in mid-run clears the indicator block.
        setc(8'h10);
        @(posedge ref_clk) reset_n <= 1'b0;
        cyc(8);
        @(posedge ref_clk) reset_n <= 1'b1;
        repeat (3) @(posedge linkClk);
        lr(8'h03);
        chk(linkRegRdata, 8'h00, "cleared by reset");
        chk({7'h00, ledDriveEnable}, 8'h01, "indicator after reset");
        end_sim();
    end
endmodule : dpc_debug_port_ctrl_tb_top
